// ---- src/fidr_pkg.sv ----
// Package for the fuse identifier reader: widths, timing and state encodings.
// Assumes a single 40 MHz core clock and a synchronous active-high reset.
package fidr_pkg;

   localparam int unsigned ID_WIDTH = 64;
   localparam int unsigned CLK_FREQ_HZ = 40_000_000;
   localparam int unsigned MAX_CLK_FREQ_MHZ = 100;
   // Fuse sense time before the first bit, in ns, and cycles derived from it (rounded up)
   localparam int unsigned FUSE_SENSE_NS = 100;
   localparam int unsigned FUSE_SENSE_CYCLES = (FUSE_SENSE_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
   localparam logic [ID_WIDTH-1:0] ID_RESET = 64'h0000_0000_0000_0000;

   typedef enum logic [3:0]
   {
      FIDR_IDLE = 4'h1,
      FIDR_SENSE = 4'h2,
      FIDR_SHIFT = 4'h4,
      FIDR_DONE = 4'h8
   } fidr_state_t;

   // Serial fuse array access
   typedef struct packed
   {
      logic rd_en;
      logic shift;
   } fidr_fuse_ctl_t;

endpackage : fidr_pkg

// ---- src/fidr_top.sv ----
// Fuse identifier reader: senses the fuse array serially after reset and
// presents the 64-bit identifier with a ready flag.
// Assumes the fuse array shifts out one bit per cycle while shift is high.
//
// How it works
// - With the clock running, the block fetches the identifier from the fuses and drives it out.
// - A high reset held for at least one clock cycle returns the block to its initial state.
// - Once loaded, the identifier stays stable on the output until reset or reconfiguration.
// - The ready flag is low in the initial state and while loading, and high only when the identifier is available.
// - At power-up the identifier output is all zeros.
`timescale 1ns/1ps
`default_nettype none

module fidr_top #(
   parameter int unsigned ID_WIDTH = fidr_pkg::ID_WIDTH,
   parameter int unsigned SENSE_CYCLES = fidr_pkg::FUSE_SENSE_CYCLES
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic fuse_bit,
   output fidr_pkg::fidr_fuse_ctl_t fuse_ctl,
   output logic [ID_WIDTH-1:0] unique_id_value,
   output logic id_ready
);

   // Counter wide enough for both the sense wait and the bit count
   localparam int unsigned CW = (ID_WIDTH > SENSE_CYCLES) ? $clog2(ID_WIDTH + 1) : $clog2(SENSE_CYCLES + 1);
   localparam logic [CW-1:0] LAST_SENSE = CW'(SENSE_CYCLES - 1);
   localparam logic [CW-1:0] LAST_BIT = CW'(ID_WIDTH - 1);
   localparam logic [ID_WIDTH-1:0] ID_ZERO = ID_WIDTH'(fidr_pkg::ID_RESET);

   // Power-up values: idle, not ready, identifier all zeros, so a running clock
   // alone starts a load even if reset never comes
   fidr_pkg::fidr_state_t state_q = fidr_pkg::FIDR_IDLE;
   fidr_pkg::fidr_state_t state_d;
   logic [CW-1:0] cnt_q = '0;
   logic [CW-1:0] cnt_d;
   logic [ID_WIDTH-1:0] shreg_q = '0;
   logic [ID_WIDTH-1:0] shreg_d;
   logic [ID_WIDTH-1:0] id_q = ID_ZERO;
   logic [ID_WIDTH-1:0] id_d;
   logic ready_q = 1'b0;
   logic ready_d;
   logic sensing;
   logic shifting;
   logic last_bit;

   // True when the state register holds the wanted state
   function automatic logic fidr_is_state(input fidr_pkg::fidr_state_t now, input fidr_pkg::fidr_state_t want);
      return now == want;
   endfunction : fidr_is_state

   // True when a phase counter has reached the final value of its phase
   function automatic logic fidr_at_end(input logic [CW-1:0] count, input logic [CW-1:0] last);
      return count == last;
   endfunction : fidr_at_end

   // Phase counter advance
   function automatic logic [CW-1:0] fidr_count_up(input logic [CW-1:0] count);
      return count + 1'b1;
   endfunction : fidr_count_up

   // New bit enters at the top, so the first bit shifted in ends up as bit 0
   function automatic logic [ID_WIDTH-1:0] fidr_shift_in(input logic [ID_WIDTH-1:0] word, input logic din);
      return {din, word[ID_WIDTH-1:1]};
   endfunction : fidr_shift_in

   // Phase decode, shared by the data path and the fuse control
   always_comb
   begin
      sensing = fidr_is_state(state_q, fidr_pkg::FIDR_SENSE);
      shifting = fidr_is_state(state_q, fidr_pkg::FIDR_SHIFT);
      last_bit = shifting && fidr_at_end(cnt_q, LAST_BIT);
   end

   // Sequencer: idle, sense wait, one shift cycle per fuse bit, then done
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         fidr_pkg::FIDR_IDLE:
         begin
            cnt_d = '0;
            state_d = fidr_pkg::FIDR_SENSE;
         end
         fidr_pkg::FIDR_SENSE:
         begin
            if (fidr_at_end(cnt_q, LAST_SENSE))
            begin
               cnt_d = '0;
               state_d = fidr_pkg::FIDR_SHIFT;
            end
            else
            begin
               cnt_d = fidr_count_up(cnt_q);
            end
         end
         fidr_pkg::FIDR_SHIFT:
         begin
            if (fidr_at_end(cnt_q, LAST_BIT))
            begin
               cnt_d = '0;
               state_d = fidr_pkg::FIDR_DONE;
            end
            else
            begin
               cnt_d = fidr_count_up(cnt_q);
            end
         end
         fidr_pkg::FIDR_DONE:
         begin
            // Held until the next reset, so the fuses are read once per reset
            state_d = fidr_pkg::FIDR_DONE;
         end
         default:
         begin
            state_d = fidr_pkg::FIDR_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_q <= fidr_pkg::FIDR_IDLE;
         cnt_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Shift register: takes one fuse bit each shift cycle
   always_comb
   begin
      shreg_d = shreg_q;
      if (shifting)
      begin
         shreg_d = fidr_shift_in(shreg_q, fuse_bit);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         shreg_q <= '0;
      end
      else
      begin
         shreg_q <= shreg_d;
      end
   end

   // Result: identifier and ready flag change together, on the last bit only,
   // so a partly shifted word never reaches the output
   always_comb
   begin
      id_d = id_q;
      ready_d = ready_q;
      if (last_bit)
      begin
         id_d = fidr_shift_in(shreg_q, fuse_bit);
         ready_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         id_q <= ID_ZERO;
         ready_q <= 1'b0;
      end
      else
      begin
         id_q <= id_d;
         ready_q <= ready_d;
      end
   end

   // Fuse control decodes straight from the state register
   always_comb
   begin
      fuse_ctl.rd_en = sensing || shifting;
      fuse_ctl.shift = shifting;
   end

   assign unique_id_value = id_q;
   assign id_ready = ready_q;

endmodule : fidr_top

`default_nettype wire

// ---- test/fidr_fuse_model.sv ----
// Fuse array model; serves one bit per shift cycle, LSB first
`timescale 1ns/1ps
`default_nettype none
module fidr_fuse_model #(parameter logic [63:0] ID = 64'h0)
(
   input wire logic core_clk,
   input wire fidr_pkg::fidr_fuse_ctl_t fuse_ctl,
   output logic fuse_bit
);
   int n = 0;
   always @(posedge core_clk) n <= fuse_ctl.shift ? n + 1 : 0;
   // Outside a frame show the inverse of the last bit
   assign fuse_bit = fuse_ctl.shift ? ID[n[5:0]] : ~ID[63];
endmodule : fidr_fuse_model
`default_nettype wire

// ---- test/fidr_top_asserts.sv ----
// Checker on the ports of fidr_top; default sense time assumed
`timescale 1ns/1ps
`default_nettype none
module fidr_top_asserts
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic fuse_bit,
   input wire fidr_pkg::fidr_fuse_ctl_t fuse_ctl,
   input wire logic [63:0] unique_id_value,
   input wire logic id_ready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_load;
      ##68 !id_ready ##1 id_ready;
   endsequence
   sequence s_frame;
      ##63 fuse_ctl.shift ##1 (!fuse_ctl.shift && id_ready);
   endsequence
   property p_frame; $rose(fuse_ctl.shift) |-> s_frame; endproperty
   a_frame: assert property (p_frame) else $error("shift frame length");
   property p_load; $fell(sys_rst) |-> s_load; endproperty
   a_load: assert property (p_load) else $error("ready timing");
   property p_zero; !id_ready |-> unique_id_value == 64'h0; endproperty
   a_zero: assert property (p_zero) else $error("id not zero");
   property p_hold; id_ready |=> id_ready && $stable(unique_id_value); endproperty
   a_hold: assert property (p_hold) else $error("id moved");
   property p_shift; fuse_ctl.shift |-> fuse_ctl.rd_en && !id_ready; endproperty
   a_shift: assert property (p_shift) else $error("shift state");
   property p_rst; disable iff (1'b0) sys_rst |=> !id_ready && unique_id_value == 64'h0 && !fuse_ctl.rd_en; endproperty
   a_rst: assert property (p_rst) else $error("reset ignored");
endmodule : fidr_top_asserts
bind fidr_top fidr_top_asserts u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .fuse_bit(fuse_bit),
   .fuse_ctl(fuse_ctl), .unique_id_value(unique_id_value), .id_ready(id_ready));
`default_nettype wire

// ---- test/fuse_id_reader_bench.sv ----
// Bench for fidr_top with a fuse model at default sense time
`timescale 1ns/1ps
`default_nettype none
module fuse_id_reader_bench;
   localparam logic [63:0] ID = 64'h8000_5a3c_0f0f_0001;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic fuse_bit;
   fidr_pkg::fidr_fuse_ctl_t fuse_ctl;
   logic [63:0] uid;
   logic id_ready;
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   fidr_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .fuse_bit(fuse_bit), .fuse_ctl(fuse_ctl),
      .unique_id_value(uid), .id_ready(id_ready));
   fidr_fuse_model #(.ID(ID)) u_fuse (.core_clk(core_clk), .fuse_ctl(fuse_ctl), .fuse_bit(fuse_bit));
   initial forever #12.5 core_clk = ~core_clk;
   task chk(string nm, logic [63:0] exp, logic [63:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task give_verdict();
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc > 600)
      begin
         n_errors++;
         give_verdict();
      end
   end
   task run_power_up();
      #1 chk("power_up_id", 64'h0, uid);
      chk("power_up_ready", 64'h0, id_ready);
      repeat (19) @(posedge core_clk);
   endtask : run_power_up
   task run_load();
      @(posedge core_clk) #1 sys_rst = 1'b0;
      repeat (68) @(posedge core_clk);
      #1 chk("ready_early", 64'h0, id_ready);
      @(posedge core_clk) #1 chk("ready", 64'h1, id_ready);
      chk("id", ID, uid);
      repeat (20) @(posedge core_clk);
      #1 chk("id_hold", ID, uid);
   endtask : run_load
   task run_reset();
      @(posedge core_clk) #1 sys_rst = 1'b1;
      @(posedge core_clk) #1 chk("rst_id", 64'h0, uid);
      chk("rst_ready", 64'h0, id_ready);
      sys_rst = 1'b0;
      repeat (30) @(posedge core_clk);
      #1 sys_rst = 1'b1;
      @(posedge core_clk) #1 chk("abort_ready", 64'h0, id_ready);
   endtask : run_reset
   initial
   begin
      run_power_up();
      run_load();
      run_reset();
      run_load();
      give_verdict();
   end
endmodule : fuse_id_reader_bench
`default_nettype wire
